// >>> verilog/mb_pkg.sv
// Shared constants and types for the Modbus TCP command checker
package mb_pkg;

    localparam logic [7:0]  FN_READ_COILS    = 8'h01;
    localparam logic [7:0]  FN_READ_INPUTS   = 8'h02;
    localparam logic [7:0]  FN_READ_HOLDING  = 8'h03;
    localparam logic [7:0]  FN_READ_INPUT_RG = 8'h04;
    localparam logic [7:0]  FN_FORCE_COIL    = 8'h05;
    localparam logic [7:0]  FN_PRESET_REG    = 8'h06;
    localparam logic [7:0]  FN_FORCE_COILS   = 8'h0f;
    localparam logic [7:0]  FN_PRESET_REGS   = 8'h10;

    localparam logic [7:0]  EXC_ILLEGAL_FN   = 8'h01;
    localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0]  EXC_ILLEGAL_VAL  = 8'h03;
    localparam logic [7:0]  EXC_BUSY         = 8'h06;
    localparam logic [7:0]  EXC_NAK          = 8'h07;
    localparam logic [7:0]  EXC_FLAG         = 8'h80;

    localparam int          PREAMBLE_LEN     = 6;
    localparam int          HEAD_LEN         = 6;
    localparam logic [7:0]  ECHO_LEN         = 8'h06;
    localparam logic [7:0]  EXC_LEN          = 8'h03;

    // Index of the last echoed byte in a reply: preamble plus six body bytes
    localparam logic [3:0]  LAST_ECHO_IDX    = 4'hb;
    localparam logic [3:0]  LAST_EXC_IDX     = 4'h8;

    localparam longint      CLK_HZ           = 100000000;
    localparam longint      BUSY_TIME_S      = 3;
    localparam longint      BUSY_CYCLES      = BUSY_TIME_S * CLK_HZ;

    localparam logic [15:0] MAX_BITS         = 16'h0040;
    localparam logic [15:0] MAX_REGS         = 16'h007b;

    typedef struct packed {
        logic [15:0] trans_id;
        logic [15:0] proto_id;
        logic [7:0]  slave;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] qty;
    } cmd_head_s;

    typedef struct packed {
        logic [7:0]  data;
        logic        last;
    } byte_beat_s;

endpackage : mb_pkg

// >>> verilog/startup_busy_timer.sv
// Start-up busy interval timer, counting down from reset
module startup_busy_timer #(
    parameter longint CYCLES = mb_pkg::BUSY_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic clk_en,
    output logic      busy
);

    logic [31:0] remaining;
    wire         done = (remaining == 32'h0);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            remaining <= 32'(CYCLES);
        else if (clk_en && !done)
            remaining <= remaining - 32'h1;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            busy <= 1'b1;
        else if (clk_en)
            busy <= (remaining > 32'h1);
    end

endmodule : startup_busy_timer

// >>> verilog/modbus_slave_command_checker.sv
// Modbus TCP slave command parser, checker and reply generator
// Notes on behaviour
// - Force-multiple-coils reply echoes slave, function and start address bytes.
// - Force-multiple-coils reply echoes the coil quantity bytes unchanged.
// - Preset-registers reply echoes slave, function, start and count bytes.
// - Unrecognised function code gets exception 01 and is not executed.
// - Unsupported data address gets exception 02, not executed; preset-registers data is still strobed out on wr_valid.
// - Data out of range for the function gets exception 03.
// - First three seconds after reset every command gets busy exception 06.
// - Nonvolatile write without write enable gets exception 07.
// - Every frame starts with six-byte preamble; length high zero, low counts rest.
// - Recognised functions are 01 02 03 04 05 06 0F 10 only.
module modbus_slave_command_checker #(
    parameter longint BUSY_CYCLES = mb_pkg::BUSY_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    output logic             rx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    input  wire logic [15:0] addr_limit,
    input  wire logic        nv_write_enable,
    input  wire logic [15:0] nv_addr_base,
    output logic             exec_valid,
    output mb_pkg::cmd_head_s exec_cmd,
    output logic             wr_valid,
    output logic [15:0]      wr_data
);

    typedef enum logic [3:0] {
        ST_RECV  = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_REPLY = 4'b0100,
        ST_DRAIN = 4'b1000
    } state_e;

    state_e            state;
    state_e            next_state;
    mb_pkg::cmd_head_s head;
    logic [7:0]        byte_idx;
    logic [7:0]        len_lo;
    logic [7:0]        exc_code;
    logic [7:0]        data_hi;
    logic [3:0]        tx_idx;
    logic              busy;
    logic              frame_bad;

    ////////////////////////////////////////////////////////////////////////////
    // Start-up interval

    startup_busy_timer #(
        .CYCLES (BUSY_CYCLES)
    ) u_busy (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .busy     (busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receive decode

    wire rx_take   = clk_en && rx_valid && rx_ready;
    wire in_body   = byte_idx >= 8'(mb_pkg::PREAMBLE_LEN);
    wire body_idx8 = (byte_idx >= 8'(mb_pkg::PREAMBLE_LEN + mb_pkg::HEAD_LEN));
    wire is_multi  = (head.func == mb_pkg::FN_FORCE_COILS)
                   || (head.func == mb_pkg::FN_PRESET_REGS);
    wire is_write  = is_multi || (head.func == mb_pkg::FN_FORCE_COIL)
                   || (head.func == mb_pkg::FN_PRESET_REG);

    wire fn_known  = (head.func == mb_pkg::FN_READ_COILS)
                   || (head.func == mb_pkg::FN_READ_INPUTS)
                   || (head.func == mb_pkg::FN_READ_HOLDING)
                   || (head.func == mb_pkg::FN_READ_INPUT_RG) || is_write;

    wire [16:0] span_end  = {1'b0, head.addr} + {1'b0, (is_write && !is_multi) ? 16'h1
                                                        : head.qty};
    wire        addr_bad  = span_end > {1'b0, addr_limit};
    wire        bit_fn    = (head.func == mb_pkg::FN_READ_COILS)
                          || (head.func == mb_pkg::FN_READ_INPUTS)
                          || (head.func == mb_pkg::FN_FORCE_COILS);
    wire        coil_bad  = (head.func == mb_pkg::FN_FORCE_COIL)
                          && (head.qty != 16'hff00) && (head.qty != 16'h0000);
    wire        qty_bad   = (!is_write || is_multi) && ((head.qty == 16'h0)
                          || (bit_fn ? head.qty > mb_pkg::MAX_BITS
                                     : head.qty > mb_pkg::MAX_REGS));
    wire        value_bad = coil_bad || qty_bad || frame_bad;
    // Only register writes reach nonvolatile storage; single coil writes never do
    wire        nv_target = ((head.func == mb_pkg::FN_PRESET_REG)
                          || (head.func == mb_pkg::FN_PRESET_REGS))
                          && (head.addr >= nv_addr_base);

    // Priority: busy, function, address, value, write protect
    wire [7:0] next_exc = busy        ? mb_pkg::EXC_BUSY
                        : !fn_known   ? mb_pkg::EXC_ILLEGAL_FN
                        : addr_bad    ? mb_pkg::EXC_ILLEGAL_ADDR
                        : value_bad   ? mb_pkg::EXC_ILLEGAL_VAL
                        : (nv_target && !nv_write_enable) ? mb_pkg::EXC_NAK
                        : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // State machine

    wire tx_take   = clk_en && tx_valid && tx_ready;
    wire tx_end    = tx_take && tx_last;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RECV:  if (rx_take && rx_last) next_state = ST_CHECK;
            ST_CHECK: next_state = ST_REPLY;
            ST_REPLY: if (tx_end) next_state = ST_RECV;
            ST_DRAIN: next_state = ST_RECV;
            default:  next_state = ST_RECV;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            state <= ST_RECV;
        else if (clk_en)
            state <= next_state;
    end

    assign rx_ready = (state == ST_RECV);

    ////////////////////////////////////////////////////////////////////////////
    // Header capture

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            head         <= '0;
            byte_idx     <= 8'h00;
            len_lo       <= 8'h00;
            frame_bad    <= 1'b0;
            data_hi      <= 8'h00;
        end
        else if (rx_take)
        begin
            byte_idx <= rx_last ? 8'h00 : byte_idx + 8'h01;
            case (byte_idx)
                8'h00: head.trans_id[15:8] <= rx_data;
                8'h01: head.trans_id[7:0]  <= rx_data;
                8'h02: head.proto_id[15:8] <= rx_data;
                8'h03: head.proto_id[7:0]  <= rx_data;
                8'h04: frame_bad <= (rx_data != 8'h00);
                8'h05: len_lo <= rx_data;
                8'h06: head.slave <= rx_data;
                8'h07: head.func <= rx_data;
                8'h08: head.addr[15:8] <= rx_data;
                8'h09: head.addr[7:0] <= rx_data;
                8'h0a: head.qty[15:8] <= rx_data;
                8'h0b: head.qty[7:0] <= rx_data;
                default: ;
            endcase
            if (byte_idx >= 8'h0d)
                data_hi <= rx_data;
            // Declared length must match bytes after the preamble
            if (rx_last && in_body && (byte_idx - 8'h05 != len_lo))
                frame_bad <= 1'b1;
        end
        else if (clk_en && state == ST_REPLY && tx_end)
        begin
            frame_bad    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register data hand-off for preset-multiple-registers

    // Data pairs start after the byte count; hi byte then lo byte per register
    wire pair_lo = rx_take && body_idx8 && (byte_idx >= 8'h0e) && !byte_idx[0];

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_valid <= 1'b0;
            wr_data  <= 16'h0000;
        end
        else if (clk_en)
        begin
            wr_valid <= pair_lo && (head.func == mb_pkg::FN_PRESET_REGS);
            if (pair_lo)
                wr_data <= {data_hi, rx_data};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and execute strobe

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            exc_code   <= 8'h00;
            exec_valid <= 1'b0;
            exec_cmd   <= '0;
        end
        else if (clk_en)
        begin
            exec_valid <= 1'b0;
            if (state == ST_CHECK)
            begin
                exc_code <= next_exc;
                // Rejected commands never reach the execute port
                if (next_exc == 8'h00)
                begin
                    exec_valid <= 1'b1;
                    exec_cmd   <= head;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reply generator

    wire       is_exc   = (exc_code != 8'h00);
    wire [3:0] last_idx = is_exc ? mb_pkg::LAST_EXC_IDX : mb_pkg::LAST_ECHO_IDX;

    logic [7:0] reply_byte;
    always_comb
    begin
        case (tx_idx)
            4'h0: reply_byte = head.trans_id[15:8];
            4'h1: reply_byte = head.trans_id[7:0];
            4'h2: reply_byte = head.proto_id[15:8];
            4'h3: reply_byte = head.proto_id[7:0];
            4'h4: reply_byte = 8'h00;
            4'h5: reply_byte = is_exc ? mb_pkg::EXC_LEN : mb_pkg::ECHO_LEN;
            4'h6: reply_byte = head.slave;
            4'h7: reply_byte = is_exc ? (head.func | mb_pkg::EXC_FLAG) : head.func;
            4'h8: reply_byte = is_exc ? exc_code : head.addr[15:8];
            4'h9: reply_byte = head.addr[7:0];
            4'ha: reply_byte = head.qty[15:8];
            4'hb: reply_byte = head.qty[7:0];
            default: reply_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
            tx_idx   <= 4'h0;
        end
        else if (clk_en)
        begin
            if (state == ST_CHECK || (state == ST_REPLY && tx_take && !tx_last))
            begin
                tx_valid <= 1'b1;
                tx_data  <= reply_byte;
                tx_last  <= (tx_idx == last_idx);
                tx_idx   <= tx_idx + 4'h1;
            end
            else if (tx_end)
            begin
                tx_valid <= 1'b0;
                tx_last  <= 1'b0;
                tx_idx   <= 4'h0;
            end
        end
    end

endmodule : modbus_slave_command_checker

// >>> verif/mb_checker_props.sv
// Port-level assertions for the Modbus slave command checker
module mb_checker_props #(
    parameter longint BUSY_CYCLES = mb_pkg::BUSY_CYCLES
) (
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic              clk_en,
    input wire logic              rx_ready,
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_data,
    input wire logic              tx_last,
    input wire logic              tx_ready,
    input wire logic [15:0]       addr_limit,
    input wire logic              nv_write_enable,
    input wire logic [15:0]       nv_addr_base,
    input wire logic              exec_valid,
    input wire mb_pkg::cmd_head_s exec_cmd
);
    logic [3:0] idx;
    logic       exc;
    longint     up;
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    // Reply byte position and start-up age, used to place each check
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            idx <= 4'h0;
            exc <= 1'b0;
            up  <= 0;
        end
        else if (clk_en)
        begin
            if (up < BUSY_CYCLES) up <= up + 1;
            if (tx_valid && tx_ready) idx <= tx_last ? 4'h0 : idx + 4'h1;
            if (tx_valid && tx_ready && idx == 4'h5) exc <= tx_data == mb_pkg::EXC_LEN;
        end
    end
    sequence stall_s;
        tx_valid && !tx_ready;
    endsequence
    sequence reply_go_s;
        tx_valid && idx == 4'h0 ##1 !exec_valid;
    endsequence
    ////////////////////////////////////////////////////////////
    stall_hold_a: assert property (stall_s |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("reply byte moved while stalled");
    rx_refuse_a: assert property (tx_valid |-> !rx_ready)
        else $error("receive open during reply");
    len_high_a: assert property (tx_valid && idx == 4'h4 |-> tx_data == 8'h00)
        else $error("length high byte not zero");
    last_pos_a: assert property (tx_valid && tx_last |->
        idx == (exc ? mb_pkg::LAST_EXC_IDX : mb_pkg::LAST_ECHO_IDX))
        else $error("reply length wrong");
    exc_func_a: assert property (tx_valid && exc && idx == 4'h7 |-> tx_data[7])
        else $error("exception function top bit clear");
    exc_code_a: assert property (tx_valid && exc && idx == 4'h8 |->
        tx_data inside {8'h01, 8'h02, 8'h03, 8'h06, 8'h07})
        else $error("unknown exception code");
    busy_exec_a: assert property (exec_valid |-> up >= BUSY_CYCLES)
        else $error("command run during start-up");
    exec_pulse_a: assert property (exec_valid |-> reply_go_s)
        else $error("accept pulse not at reply start");
    fn_known_a: assert property (exec_valid |-> exec_cmd.func inside
        {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10})
        else $error("unknown function executed");
    addr_range_a: assert property (exec_valid && !(exec_cmd.func inside {8'h05, 8'h06}) |->
        {1'b0, exec_cmd.addr} + {1'b0, exec_cmd.qty} <= {1'b0, addr_limit})
        else $error("unsupported address executed");
    nv_guard_a: assert property (exec_valid && exec_cmd.func inside {8'h06, 8'h10} &&
        exec_cmd.addr >= nv_addr_base |-> nv_write_enable)
        else $error("nonvolatile write without enable");
    coil_qty_a: assert property (exec_valid && exec_cmd.func == 8'h0f |->
        exec_cmd.qty inside {[16'h0001:16'h0040]})
        else $error("coil count out of range executed");
endmodule : mb_checker_props

bind modbus_slave_command_checker mb_checker_props #(.BUSY_CYCLES(BUSY_CYCLES)) props_inst (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .addr_limit(addr_limit), .nv_write_enable(nv_write_enable),
    .nv_addr_base(nv_addr_base), .exec_valid(exec_valid), .exec_cmd(exec_cmd));

// >>> verif/mb_master_model.sv
// Behavioural remote master: sends request frames and paces the reply
module mb_master_model (
    input  wire logic  core_clk,
    input  wire logic  rx_ready,
    input  wire logic  tx_valid,
    input  wire logic  tx_last,
    output logic       rx_valid,
    output logic [7:0] rx_data,
    output logic       rx_last,
    output logic       tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_last  = 1'b0;
        tx_ready = 1'b0;
    end
    // Random back-pressure so replies are taken both promptly and slowly
    always @(posedge core_clk)
        tx_ready <= ($urandom % 4) != 0;
    task automatic send(input logic [7:0] f[$]);
        for (int i = 0; i < f.size(); i++)
        begin
            rx_valid <= 1'b1;
            rx_data  <= f[i];
            rx_last  <= i == f.size() - 1;
            do @(posedge core_clk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        // A released line must not look like a repeat of the last byte
        rx_data  <= ~f[f.size() - 1];
        do @(posedge core_clk); while (!(tx_valid && tx_ready && tx_last));
    endtask : send
endmodule : mb_master_model

// >>> verif/modbus_slave_command_checker_tb.sv
// Self-checking bench for the Modbus slave command checker
module modbus_slave_command_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              core_clk = 1'b0;
    logic              resetn = 1'b0;
    logic              clk_en = 1'b1;
    logic [15:0]       addr_limit = 16'h0100;
    logic              nv_write_enable = 1'b0;
    logic [15:0]       nv_addr_base = 16'h0080;
    logic              rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic              exec_valid, wr_valid;
    logic [7:0]        rx_data, tx_data;
    logic [15:0]       wr_data;
    mb_pkg::cmd_head_s exec_cmd;
    logic [7:0]        exp_q[$];
    logic [39:0]       exec_q[$];
    logic [39:0]       exec_exp;
    logic [15:0]       wr_q[$];
    logic [7:0]        fns[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
    logic [7:0]        bad[4] = '{8'h00, 8'h07, 8'h0e, 8'h11};
    int                miscompares = 0;
    int                checked = 0;
    modbus_slave_command_checker #(.BUSY_CYCLES(50)) modbus_slave_command_checker_inst (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .addr_limit(addr_limit),
        .nv_write_enable(nv_write_enable), .nv_addr_base(nv_addr_base),
        .exec_valid(exec_valid), .exec_cmd(exec_cmd), .wr_valid(wr_valid), .wr_data(wr_data));
    mb_master_model mb_master_model_inst (
        .core_clk(core_clk), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_last(tx_last),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready));
    initial forever #5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // Builds one request, notes the expected reply, then hands it to the master
    task automatic cmd(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] q,
                       input logic [7:0] exc);
        logic [7:0]  f[$];
        logic [7:0]  b[$];
        logic [15:0] tid;
        logic [7:0]  sl;
        int          n;
        tid = 16'($urandom);
        sl = 8'($urandom);
        n = fn == 8'h10 ? 2 * q : (q + 7) / 8;
        b = '{sl, fn, a[15:8], a[7:0], q[15:8], q[7:0]};
        if (fn == 8'h0f || fn == 8'h10)
        begin
            b.push_back(8'(n));
            for (int i = 0; i < n; i++)
                b.push_back(8'($urandom));
        end
        if (fn == 8'h10)
            for (int i = 0; i < n; i += 2)
                wr_q.push_back({b[7 + i], b[8 + i]});
        f = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'(b.size())};
        f = {f, b};
        exp_q = {exp_q, tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00};
        if (exc != 8'h00)
            exp_q = {exp_q, mb_pkg::EXC_LEN, sl, fn | mb_pkg::EXC_FLAG, exc};
        else
        begin
            exp_q = {exp_q, mb_pkg::ECHO_LEN, sl, fn, a[15:8], a[7:0], q[15:8], q[7:0]};
            exec_q.push_back({fn, a, q});
        end
        mb_master_model_inst.send(f);
    endtask : cmd
    ////////////////////////////////////////////////////////////
    always @(posedge core_clk)
    begin
        if (resetn && tx_valid && tx_ready)
            check(24'(tx_data), 24'(exp_q.pop_front()));
        if (resetn && exec_valid)
        begin
            exec_exp = exec_q.pop_front();
            check({exec_cmd.func, exec_cmd.addr}, exec_exp[39:16]);
            check(24'(exec_cmd.qty), 24'(exec_exp[15:0]));
        end
        if (resetn && wr_valid)
            check(24'(wr_data), 24'(wr_q.pop_front()));
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        stop_test();
    end
    initial
    begin
        void'($urandom(32'h1861));
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        cmd(8'h03, 16'h0000, 16'h0001, mb_pkg::EXC_BUSY);
        repeat (50) @(posedge core_clk);
        $display("test busy done");
        foreach (fns[i])
            cmd(fns[i], 16'($urandom_range(63, 0)), fns[i] == 8'h05 ? 16'hff00 :
                16'($urandom_range(32, 1)), 8'h00);
        cmd(8'h05, 16'h0003, 16'h0000, 8'h00);
        foreach (bad[i])
            cmd(bad[i], 16'h0000, 16'h0001, mb_pkg::EXC_ILLEGAL_FN);
        $display("test functions done");
        cmd(8'h03, 16'h00fe, 16'h0002, 8'h00);
        cmd(8'h03, 16'h00ff, 16'h0002, mb_pkg::EXC_ILLEGAL_ADDR);
        cmd(8'h06, 16'h0100, 16'h0001, mb_pkg::EXC_ILLEGAL_ADDR);
        addr_limit <= 16'h0010;
        cmd(8'h0f, 16'h0008, 16'h0009, mb_pkg::EXC_ILLEGAL_ADDR);
        addr_limit <= 16'h0100;
        $display("test address done");
        cmd(8'h01, 16'h0000, 16'h0040, 8'h00);
        cmd(8'h01, 16'h0000, 16'h0041, mb_pkg::EXC_ILLEGAL_VAL);
        cmd(8'h03, 16'h0000, 16'h007c, mb_pkg::EXC_ILLEGAL_VAL);
        cmd(8'h10, 16'h0000, 16'h0000, mb_pkg::EXC_ILLEGAL_VAL);
        cmd(8'h05, 16'h0000, 16'h1234, mb_pkg::EXC_ILLEGAL_VAL);
        $display("test value done");
        cmd(8'h06, 16'h0080, 16'h0005, mb_pkg::EXC_NAK);
        cmd(8'h10, 16'h0080, 16'h0002, mb_pkg::EXC_NAK);
        cmd(8'h05, 16'h0080, 16'hff00, 8'h00);
        nv_write_enable <= 1'b1;
        cmd(8'h06, 16'h0080, 16'h0005, 8'h00);
        cmd(8'h10, 16'h0080, 16'h0002, 8'h00);
        nv_write_enable <= 1'b0;
        $display("test nonvolatile done");
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        cmd(8'h0f, 16'h0000, 16'h0001, mb_pkg::EXC_BUSY);
        $display("test second reset done");
        // Let the monitor take the last reply byte before the queues are counted
        repeat (2) @(posedge core_clk);
        check(24'(exp_q.size() + exec_q.size() + wr_q.size()), 24'h000000);
        stop_test();
    end
endmodule : modbus_slave_command_checker_tb
